// file: hw/pmr_rx_if.sv
`timescale 1ns/100ps
`default_nettype none

module pmr_rx_if (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic RMII_STRAP_I,
  input wire logic SERIAL_STRAP_I,
  input wire logic SPEED_100_I,
  input wire logic FULL_DUPLEX_I,
  input wire logic HEARTBEAT_EN_I,
  input wire logic TX_EN_I,
  input wire logic LINE_ACTIVE_I,
  input wire logic LINE_VALID_I,
  input wire logic [3:0] LINE_DATA_I,
  input wire logic LINE_ERR_I,
  input wire logic LINE_LAST_I,
  output logic LINE_READY_O,
  output logic RX_CLK_O,
  output logic [3:0] RXD_O,
  output logic RX_DV_O,
  output logic RX_ER_O,
  output logic CRS_O,
  output logic COL_O,
  output logic SYSTEM_CLOCK_OUT_O
);

  // ==========================================================================
  // Clock dividers.
  logic c25;
  logic c2m5;
  logic c10;
  logic c50;
  logic t25;
  logic t2m5;
  logic t10;
  logic t50;

  pmr_clkdiv #(.HALF(pmr_pkg::HALF_25M)) u_div25 (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .level_o(c25),
    .fall_o(t25)
  );

  pmr_clkdiv #(.HALF(pmr_pkg::HALF_2M5)) u_div2m5 (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .level_o(c2m5),
    .fall_o(t2m5)
  );

  pmr_clkdiv #(.HALF(pmr_pkg::HALF_10M)) u_div10 (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .level_o(c10),
    .fall_o(t10)
  );

  pmr_clkdiv #(.HALF(pmr_pkg::HALF_50M)) u_div50 (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .level_o(c50),
    .fall_o(t50)
  );

  // ==========================================================================
  // Receive buffer.
  pmr_pkg::pmr_state_t st;
  pmr_pkg::pmr_state_t next_st;
  pmr_pkg::pmr_word_t in_word;
  pmr_pkg::pmr_word_t out_word;
  logic fifo_ready;
  logic fifo_valid;
  logic pop;

  assign in_word = '{last: LINE_LAST_I, err: LINE_ERR_I, data: LINE_DATA_I};

  pmr_fifo #(.WIDTH(pmr_pkg::WORD_W), .DEPTH(pmr_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .in_valid_i(LINE_VALID_I),
    .in_ready_o(fifo_ready),
    .in_data_i(in_word),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(out_word)
  );

  // ==========================================================================
  // Lane mapping per interface mode.
  function automatic logic [3:0] lanes(input logic rmii, input logic ser,
                                       input logic [3:0] d);
    logic [3:0] r;
    r = d;
    if (rmii) begin
      r = {2'h0, d[1:0]};
    end else if (ser) begin
      r = {3'h0, d[0]};
    end
    return r;
  endfunction

  // ==========================================================================
  // Next state.
  logic tick;
  logic do_load;
  logic do_shift;
  logic do_drop;
  logic hb_start;
  logic [3:0] load_nib;
  logic [3:0] shift_nib;

  always_comb begin
    next_st = st;
    tick = 1'b0;
    do_load = 1'b0;
    do_shift = 1'b0;
    do_drop = 1'b0;
    load_nib = out_word.err ? (out_word.data ^ pmr_pkg::CORRUPT_MASK) : out_word.data;
    shift_nib = st.rmii ? (st.sh >> 2) : (st.sh >> 1);
    if (!st.strap_done) begin
      next_st.strap_done = 1'b1;
      next_st.rmii = RMII_STRAP_I;
      next_st.serial_10m_mode = SERIAL_STRAP_I && !RMII_STRAP_I;
    end
    if (st.strap_done) begin
      if (st.rmii) begin
        tick = t50;
      end else if (st.serial_10m_mode) begin
        tick = t10;
      end else begin
        tick = SPEED_100_I ? t25 : t2m5;
      end
    end
    case (st.fsm)
      pmr_pkg::ST_IDLE: begin
        do_load = tick && fifo_valid;
      end
      pmr_pkg::ST_FRAME: begin
        if (tick) begin
          if (st.beats != pmr_pkg::BEATS_ZERO) begin
            do_shift = 1'b1;
          end else if (st.last_sent || !fifo_valid) begin
            do_drop = 1'b1;
          end else begin
            do_load = 1'b1;
          end
        end
      end
      default: begin
        do_drop = 1'b1;
      end
    endcase
    if (do_load) begin
      next_st.fsm = pmr_pkg::ST_FRAME;
      next_st.sh = load_nib;
      next_st.last_sent = out_word.last;
      next_st.rxd = lanes(st.rmii, st.serial_10m_mode, load_nib);
      next_st.dv = !st.serial_10m_mode;
      next_st.er = out_word.err && SPEED_100_I && !st.serial_10m_mode;
      if (st.rmii) begin
        next_st.beats = pmr_pkg::BEATS_RMII;
      end else if (st.serial_10m_mode) begin
        next_st.beats = pmr_pkg::BEATS_SERIAL;
      end else begin
        next_st.beats = pmr_pkg::BEATS_MII;
      end
    end
    if (do_shift) begin
      next_st.sh = shift_nib;
      next_st.beats = st.beats - pmr_pkg::BEATS_ONE;
      next_st.rxd = lanes(st.rmii, st.serial_10m_mode, shift_nib);
    end
    if (do_drop) begin
      next_st.fsm = pmr_pkg::ST_IDLE;
      next_st.rxd = pmr_pkg::NIB_ZERO;
      next_st.dv = 1'b0;
      next_st.er = 1'b0;
      next_st.beats = pmr_pkg::BEATS_ZERO;
      next_st.last_sent = 1'b0;
    end
    // Carrier stays up while buffered data drains so the frame is covered.
    next_st.crs = LINE_ACTIVE_I || (next_st.fsm == pmr_pkg::ST_FRAME);
    next_st.tx_prev = TX_EN_I;
    hb_start = st.tx_prev && !TX_EN_I && !SPEED_100_I && !FULL_DUPLEX_I &&
               HEARTBEAT_EN_I && !st.rmii && st.strap_done;
    if (hb_start) begin
      next_st.hb_cnt = pmr_pkg::HB_LOAD;
    end else if (st.hb_cnt != pmr_pkg::HB_ZERO) begin
      next_st.hb_cnt = st.hb_cnt - 8'h01;
    end
    next_st.col = !st.rmii && !FULL_DUPLEX_I &&
                  ((TX_EN_I && LINE_ACTIVE_I) || (st.hb_cnt != pmr_pkg::HB_ZERO));
    if (st.rmii) begin
      next_st.rx_clk = 1'b0;
    end else if (st.serial_10m_mode) begin
      next_st.rx_clk = c10;
    end else begin
      next_st.rx_clk = SPEED_100_I ? c25 : c2m5;
    end
    next_st.sys_clk_out = st.rmii ? c50 : c25;
  end

  assign pop = do_load;

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st <= pmr_pkg::PMR_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs.
  assign LINE_READY_O = fifo_ready;
  assign RX_CLK_O = st.rx_clk;
  assign RXD_O = st.rxd;
  assign RX_DV_O = st.dv;
  assign RX_ER_O = st.er;
  assign CRS_O = st.crs;
  assign COL_O = st.col;
  assign SYSTEM_CLOCK_OUT_O = st.sys_clk_out;

  // ==========================================================================
  // Checks.
  a_rmii_rxclk_low: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    st.rmii && $past(st.rmii) |-> !RX_CLK_O)
    else $error("receive clock toggles in RMII mode");

  a_serial_no_flags: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    st.serial_10m_mode |-> !RX_DV_O && !RX_ER_O)
    else $error("valid or error driven in serial mode");

  a_idle_outputs_zero: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    st.fsm == pmr_pkg::ST_IDLE |-> RXD_O == 4'h0 && !RX_DV_O && !RX_ER_O)
    else $error("receive outputs not zero outside packet");

  a_error_in_frame: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    RX_ER_O |-> RX_DV_O && !$past(st.serial_10m_mode))
    else $error("receive error outside valid data");

  a_rmii_dibit_lanes: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    st.rmii && $past(st.rmii) |-> RXD_O[3:2] == 2'h0)
    else $error("upper data lines used in RMII mode");

  a_serial_bit_lane: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    st.serial_10m_mode && $past(st.serial_10m_mode) |-> RXD_O[3:1] == 3'h0)
    else $error("upper data lines used in serial mode");

  a_crs_on_activity: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    LINE_ACTIVE_I |=> CRS_O)
    else $error("carrier sense missing while medium busy");

  a_col_overlap: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    TX_EN_I && LINE_ACTIVE_I && !FULL_DUPLEX_I && !st.rmii |=> COL_O)
    else $error("collision not flagged on overlap");

  a_full_duplex_col: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    $past(FULL_DUPLEX_I) |-> !COL_O)
    else $error("collision driven in full duplex");

  a_hb_load: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    $fell(TX_EN_I) && !SPEED_100_I && !FULL_DUPLEX_I && HEARTBEAT_EN_I &&
    !st.rmii && st.strap_done |=> st.hb_cnt == pmr_pkg::HB_LOAD)
    else $error("heartbeat not started after transmit");

  a_hb_drives_col: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    st.hb_cnt != 8'h00 && !FULL_DUPLEX_I && !st.rmii |=> COL_O)
    else $error("heartbeat pulse missing on collision");

  a_sysclk_mii_half: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    $rose(SYSTEM_CLOCK_OUT_O) && !st.rmii && $past(st.strap_done) |->
    SYSTEM_CLOCK_OUT_O [*4] ##1 !SYSTEM_CLOCK_OUT_O)
    else $error("system clock out not 25 MHz in MII mode");

  a_rxclk_100_half: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    $rose(RX_CLK_O) && !st.rmii && !st.serial_10m_mode && SPEED_100_I &&
    $past(SPEED_100_I) |-> RX_CLK_O [*4] ##1 !RX_CLK_O)
    else $error("receive clock not 25 MHz at 100");

  a_rxclk_serial: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    $rose(RX_CLK_O) && st.serial_10m_mode && $past(st.serial_10m_mode) |->
    ##9 RX_CLK_O ##1 !RX_CLK_O)
    else $error("receive clock not 10 MHz in serial mode");

  a_strap_hold: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    st.strap_done |=> $stable(st.rmii) && $stable(st.serial_10m_mode))
    else $error("strap values changed after capture");

endmodule

`default_nettype wire

// file: hw/pmr_pkg.sv
package pmr_pkg;

  // ==========================================================================
  // Clock rates and divider half periods.
  localparam int SYS_CLK_KHZ = 200000;
  localparam int CLK_25M_KHZ = 25000;
  localparam int CLK_2M5_KHZ = 2500;
  localparam int CLK_10M_KHZ = 10000;
  localparam int CLK_50M_KHZ = 50000;
  localparam int HALF_25M = SYS_CLK_KHZ / (2 * CLK_25M_KHZ);
  localparam int HALF_2M5 = SYS_CLK_KHZ / (2 * CLK_2M5_KHZ);
  localparam int HALF_10M = SYS_CLK_KHZ / (2 * CLK_10M_KHZ);
  localparam int HALF_50M = SYS_CLK_KHZ / (2 * CLK_50M_KHZ);
  localparam int DIV_CNT_W = 8;

  // ==========================================================================
  // Heartbeat pulse length.
  localparam int HB_PULSE_NS = 1000;
  localparam int HB_CYCLES = (HB_PULSE_NS * (SYS_CLK_KHZ / 1000)) / 1000;
  localparam int HB_CNT_W = 8;
  localparam logic [HB_CNT_W-1:0] HB_LOAD = HB_CNT_W'(HB_CYCLES);
  localparam logic [HB_CNT_W-1:0] HB_ZERO = 8'h00;

  // ==========================================================================
  // Data path layout.
  localparam int NIB_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam logic [1:0] BEATS_MII = 2'h0;
  localparam logic [1:0] BEATS_RMII = 2'h1;
  localparam logic [1:0] BEATS_SERIAL = 2'h3;
  localparam logic [1:0] BEATS_ZERO = 2'h0;
  localparam logic [1:0] BEATS_ONE = 2'h1;
  localparam logic [3:0] CORRUPT_MASK = 4'hf;
  localparam logic [3:0] NIB_ZERO = 4'h0;

  typedef struct packed {
    logic last;
    logic err;
    logic [3:0] data;
  } pmr_word_t;

  localparam int WORD_W = $bits(pmr_word_t);

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_FRAME = 2'h2
  } pmr_fsm_t;

  typedef struct packed {
    logic strap_done;
    logic rmii;
    logic serial_10m_mode;
    pmr_fsm_t fsm;
    logic [3:0] sh;
    logic [1:0] beats;
    logic last_sent;
    logic [3:0] rxd;
    logic dv;
    logic er;
    logic crs;
    logic col;
    logic rx_clk;
    logic sys_clk_out;
    logic tx_prev;
    logic [HB_CNT_W-1:0] hb_cnt;
  } pmr_state_t;

  localparam pmr_state_t PMR_STATE_RST = '{
    strap_done: 1'b0, rmii: 1'b0, serial_10m_mode: 1'b0, fsm: ST_IDLE,
    sh: 4'h0, beats: 2'h0, last_sent: 1'b0, rxd: 4'h0, dv: 1'b0, er: 1'b0,
    crs: 1'b0, col: 1'b0, rx_clk: 1'b0, sys_clk_out: 1'b0, tx_prev: 1'b0,
    hb_cnt: 8'h00
  };

endpackage

// file: hw/pmr_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module pmr_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic full;
    logic empty;
  } pmr_fifo_state_t;

  // ==========================================================================
  // Pointer state.
  pmr_fifo_state_t st;
  pmr_fifo_state_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = in_valid_i && !st.full;
  assign pop = out_ready_i && !st.empty;
  assign in_ready_o = !st.full;
  assign out_valid_o = !st.empty;
  assign out_data_o = mem[st.rptr[AW-1:0]];

  always_comb begin
    next_st = st;
    next_st.wptr = st.wptr + (AW+1)'(push);
    next_st.rptr = st.rptr + (AW+1)'(pop);
    next_st.full = (next_st.wptr[AW] != next_st.rptr[AW]) &&
                   (next_st.wptr[AW-1:0] == next_st.rptr[AW-1:0]);
    next_st.empty = (next_st.wptr == next_st.rptr);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '{wptr: '0, rptr: '0, full: 1'b0, empty: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Storage.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[st.wptr[AW-1:0]] <= in_data_i;
    end
  end

endmodule

`default_nettype wire

// file: hw/pmr_clkdiv.sv
`timescale 1ns/100ps
`default_nettype none

module pmr_clkdiv #(
  parameter int HALF = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic level_o,
  output logic fall_o
);

  typedef struct packed {
    logic [pmr_pkg::DIV_CNT_W-1:0] cnt;
    logic lvl;
  } pmr_div_state_t;

  // ==========================================================================
  // Half period counter.
  pmr_div_state_t st;
  pmr_div_state_t next_st;
  logic wrap;

  assign wrap = (st.cnt == pmr_pkg::DIV_CNT_W'(HALF - 1));
  assign level_o = st.lvl;
  assign fall_o = wrap && st.lvl;

  always_comb begin
    next_st = st;
    if (wrap) begin
      next_st.cnt = '0;
      next_st.lvl = !st.lvl;
    end else begin
      next_st.cnt = st.cnt + pmr_pkg::DIV_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '{cnt: '0, lvl: 1'b0};
    end else begin
      st <= next_st;
    end
  end

endmodule

`default_nettype wire

// file: tb/pmr_mac_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Receiving controller: rebuilds nibbles from the receive pins.
module pmr_mac_model (
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic rx_clk_i,
  input wire logic ref_clk_i,
  input wire logic [3:0] rxd_i,
  input wire logic rx_dv_i,
  input wire logic rx_er_i,
  input wire logic crs_i
);
  logic [3:0] got_q[$];
  int frames;
  int nb;
  logic [3:0] acc;
  logic er_seen;
  logic dv_seen;
  logic hi_seen;
  logic crs_lo;
  logic in_frame;
  wire logic samp = (mode_i == 2'h1) ? ref_clk_i : rx_clk_i;
  wire logic frm = (mode_i == 2'h2) ? crs_i : rx_dv_i;

  always @(posedge samp or posedge rst_i) begin
    if (rst_i) begin
      got_q.delete();
      frames = 0;
      nb = 0;
      acc = 4'h0;
      er_seen = 1'b0;
      dv_seen = 1'b0;
      hi_seen = 1'b0;
      crs_lo = 1'b0;
      in_frame = 1'b0;
    end else if (frm) begin
      in_frame = 1'b1;
      er_seen |= rx_er_i;
      dv_seen |= rx_dv_i;
      crs_lo |= !crs_i;
      if (mode_i == 2'h0) begin
        got_q.push_back(rxd_i);
      end else begin
        hi_seen |= (mode_i == 2'h1) ? |rxd_i[3:2] : |rxd_i[3:1];
        acc = (mode_i == 2'h1) ? {rxd_i[1:0], acc[3:2]} : {rxd_i[0], acc[3:1]};
        nb = nb + ((mode_i == 2'h1) ? 2 : 1);
        if (nb == 4) begin
          got_q.push_back(acc);
          nb = 0;
        end
      end
    end else if (in_frame) begin
      in_frame = 1'b0;
      frames++;
    end
  end
endmodule

`default_nettype wire

// file: tb/tb_phy_mac_receive_clock_interface.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Receive interface bench.
module tb_phy_mac_receive_clock_interface;
  logic SYS_CLK_I, RST_I, RMII_STRAP_I, SERIAL_STRAP_I, SPEED_100_I, FULL_DUPLEX_I;
  logic HEARTBEAT_EN_I, TX_EN_I, LINE_ACTIVE_I, LINE_VALID_I, LINE_ERR_I, LINE_LAST_I;
  logic [3:0] LINE_DATA_I;
  logic LINE_READY_O, RX_CLK_O, RX_DV_O, RX_ER_O, CRS_O, COL_O, SYSTEM_CLOCK_OUT_O;
  logic [3:0] RXD_O;
  logic [1:0] mode;
  int n_mismatch;
  int n_tests;
  int stalls;
  int per;

  pmr_rx_if dut_u (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .RMII_STRAP_I(RMII_STRAP_I),
    .SERIAL_STRAP_I(SERIAL_STRAP_I), .SPEED_100_I(SPEED_100_I),
    .FULL_DUPLEX_I(FULL_DUPLEX_I), .HEARTBEAT_EN_I(HEARTBEAT_EN_I), .TX_EN_I(TX_EN_I),
    .LINE_ACTIVE_I(LINE_ACTIVE_I), .LINE_VALID_I(LINE_VALID_I), .LINE_DATA_I(LINE_DATA_I),
    .LINE_ERR_I(LINE_ERR_I), .LINE_LAST_I(LINE_LAST_I), .LINE_READY_O(LINE_READY_O),
    .RX_CLK_O(RX_CLK_O), .RXD_O(RXD_O), .RX_DV_O(RX_DV_O), .RX_ER_O(RX_ER_O),
    .CRS_O(CRS_O), .COL_O(COL_O), .SYSTEM_CLOCK_OUT_O(SYSTEM_CLOCK_OUT_O));

  pmr_mac_model mac_u (.rst_i(RST_I), .mode_i(mode), .rx_clk_i(RX_CLK_O),
    .ref_clk_i(SYSTEM_CLOCK_OUT_O), .rxd_i(RXD_O), .rx_dv_i(RX_DV_O), .rx_er_i(RX_ER_O),
    .crs_i(CRS_O));

  initial begin
    SYS_CLK_I = 1'b0;
    forever #2.5 SYS_CLK_I = ~SYS_CLK_I;
  end

  // ==========================================================================
  // Shared tasks.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic timeout(input string what);
    n_mismatch++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    complete_run();
  endtask

  task automatic do_reset(input logic r, input logic s);
    RST_I = 1'b1;
    RMII_STRAP_I = r;
    SERIAL_STRAP_I = s;
    mode = r ? 2'h1 : (s ? 2'h2 : 2'h0);
    repeat (5) @(negedge SYS_CLK_I);
    RST_I = 1'b0;
    @(negedge SYS_CLK_I);
  endtask

  function automatic logic pick(input logic sel);
    return sel ? SYSTEM_CLOCK_OUT_O : RX_CLK_O;
  endfunction

  task automatic period(input logic sel, output int n);
    int i;
    n = 0;
    for (i = 0; i < 400 && pick(sel); i++) @(negedge SYS_CLK_I);
    if (i == 400) timeout("clock low");
    for (i = 0; i < 400 && !pick(sel); i++) @(negedge SYS_CLK_I);
    if (i == 400) timeout("clock rise");
    for (i = 0; i < 400 && pick(sel); i++) begin
      @(negedge SYS_CLK_I);
      n++;
    end
    if (i == 400) timeout("clock fall");
    for (i = 0; i < 400 && !pick(sel); i++) begin
      @(negedge SYS_CLK_I);
      n++;
    end
    if (i == 400) timeout("clock period");
  endtask

  task automatic send_frame(input int n, input logic [3:0] base, input int errpos);
    int i;
    int k;
    for (i = 0; i < n; i++) begin
      LINE_VALID_I = 1'b1;
      LINE_DATA_I = base + 4'(i);
      LINE_ERR_I = (i == errpos);
      LINE_LAST_I = (i == n - 1);
      for (k = 0; k < 2000 && !LINE_READY_O; k++) begin
        stalls++;
        @(negedge SYS_CLK_I);
      end
      if (k == 2000) timeout("line ready");
      @(negedge SYS_CLK_I);
    end
    LINE_VALID_I = 1'b0;
    LINE_ERR_I = 1'b0;
    LINE_LAST_I = 1'b0;
  endtask

  task automatic check_frame(input int n, input logic [3:0] base, input int errpos);
    int i;
    for (i = 0; i < 5000 && mac_u.frames < 1; i++) @(negedge SYS_CLK_I);
    if (i == 5000) timeout("frame end");
    check("nibble count", mac_u.got_q.size(), n);
    for (i = 0; i < n && i < mac_u.got_q.size(); i++) begin
      check("nibble", mac_u.got_q[i], (base + 4'(i)) ^ ((i == errpos) ? 4'hf : 4'h0));
    end
  endtask

  task automatic count_high(input int cycles, output int n);
    n = 0;
    repeat (cycles) begin
      @(negedge SYS_CLK_I);
      n += COL_O;
    end
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_mii100();
    do_reset(1'b0, 1'b0);
    check("idle rx", {RX_DV_O, RX_ER_O, RXD_O, COL_O, LINE_READY_O}, 8'h01);
    SPEED_100_I = 1'b1;
    LINE_ACTIVE_I = 1'b1;
    period(1'b0, per);
    check("rx clock 25M", per, 8);
    period(1'b1, per);
    check("sys clock 25M", per, 8);
    check("mii carrier idle", CRS_O, 1'b1);
    send_frame(5, 4'h3, 2);
    check_frame(5, 4'h3, 2);
    check("mii error", mac_u.er_seen, 1'b1);
    check("mii carrier", mac_u.crs_lo, 1'b0);
    LINE_ACTIVE_I = 1'b0;
    repeat (20) @(negedge SYS_CLK_I);
    check("after frame", {RX_DV_O, RX_ER_O, RXD_O}, 6'h00);
    check("carrier after frame", CRS_O, 1'b0);
    $display("test mii100 done");
  endtask

  task automatic t_mii10_fill();
    do_reset(1'b0, 1'b0);
    SPEED_100_I = 1'b0;
    period(1'b0, per);
    check("rx clock 2M5", per, 80);
    stalls = 0;
    send_frame(20, 4'h0, 5);
    check("buffer refused", stalls > 0, 1'b1);
    check_frame(20, 4'h0, 5);
    check("no error at 10", mac_u.er_seen, 1'b0);
    check("drained ready", LINE_READY_O, 1'b1);
    $display("test mii10 fill done");
  endtask

  task automatic t_rmii();
    do_reset(1'b1, 1'b0);
    RMII_STRAP_I = 1'b0;
    SPEED_100_I = 1'b1;
    FULL_DUPLEX_I = 1'b0;
    TX_EN_I = 1'b1;
    LINE_ACTIVE_I = 1'b1;
    count_high(10, per);
    check("rmii collision", per, 0);
    TX_EN_I = 1'b0;
    LINE_ACTIVE_I = 1'b0;
    period(1'b1, per);
    check("sys clock 50M", per, 4);
    check("rx clock unused", RX_CLK_O, 1'b0);
    send_frame(3, 4'ha, 1);
    check_frame(3, 4'ha, 1);
    check("rmii error", mac_u.er_seen, 1'b1);
    check("rmii upper lines", mac_u.hi_seen, 1'b0);
    check("crs_dv", mac_u.crs_lo, 1'b0);
    $display("test rmii done");
  endtask

  task automatic t_serial();
    do_reset(1'b0, 1'b1);
    SPEED_100_I = 1'b0;
    period(1'b0, per);
    check("rx clock 10M", per, 20);
    send_frame(2, 4'h5, 0);
    check_frame(2, 4'h5, 0);
    check("serial valid error", {mac_u.dv_seen, mac_u.er_seen}, 2'h0);
    check("serial upper lines", mac_u.hi_seen, 1'b0);
    TX_EN_I = 1'b1;
    LINE_ACTIVE_I = 1'b1;
    repeat (2) @(negedge SYS_CLK_I);
    check("serial collision", COL_O, 1'b1);
    TX_EN_I = 1'b0;
    LINE_ACTIVE_I = 1'b0;
    $display("test serial done");
  endtask

  task automatic t_collision();
    do_reset(1'b0, 1'b0);
    SPEED_100_I = 1'b1;
    HEARTBEAT_EN_I = 1'b1;
    TX_EN_I = 1'b1;
    LINE_ACTIVE_I = 1'b1;
    repeat (2) @(negedge SYS_CLK_I);
    check("half collision", COL_O, 1'b1);
    FULL_DUPLEX_I = 1'b1;
    repeat (2) @(negedge SYS_CLK_I);
    check("full collision", COL_O, 1'b0);
    LINE_ACTIVE_I = 1'b0;
    SPEED_100_I = 1'b0;
    for (int d = 1; d >= 0; d--) begin
      FULL_DUPLEX_I = d[0];
      TX_EN_I = 1'b1;
      repeat (5) @(negedge SYS_CLK_I);
      TX_EN_I = 1'b0;
      count_high(300, per);
      check("heartbeat length", per, d[0] ? 0 : 200);
    end
    $display("test collision done");
  endtask

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    stalls = 0;
    mode = 2'h0;
    RST_I = 1'b1;
    {RMII_STRAP_I, SERIAL_STRAP_I, SPEED_100_I, FULL_DUPLEX_I, HEARTBEAT_EN_I} = 5'h00;
    {TX_EN_I, LINE_ACTIVE_I, LINE_VALID_I, LINE_ERR_I, LINE_LAST_I} = 5'h00;
    LINE_DATA_I = 4'h0;
    t_mii100();
    t_mii10_fill();
    t_rmii();
    t_serial();
    t_collision();
    complete_run();
  end
endmodule

`default_nettype wire
